// *** hw/fifo_params.svh ***
`ifndef FIFO_PARAMS_SVH
`define FIFO_PARAMS_SVH
// ----------------------------------------
// Geometry and defaults
// ----------------------------------------
`define FIFO_DEPTH          65536
`define OFS_DEFAULT_PAR     16'h007F
`define OFS_DEFAULT_SER     16'h03FF
// ----------------------------------------
// Timing counts, in link clock events
// ----------------------------------------
`define FALL_TRANSITIONS    2'h3
`define REPLAY_EDGES        2'h2
// ----------------------------------------
// Pin synchroniser reset pattern
// ----------------------------------------
`define PIN_RESET           20'h3BE00
// ----------------------------------------
// Register map
// ----------------------------------------
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_OFFSETS         8'h08
`define REG_LEVEL           8'h0C
`define CTRL_SOFT_CLEAR_BIT 0
`endif

// *** hw/fifo_pkg.sv ***
`default_nettype none
package fifo_pkg;
	typedef logic [8:0] word_t;
	typedef enum logic [1:0] {out_none, out_falling, out_held} out_state_e;
endpackage : fifo_pkg
`default_nettype wire

// *** hw/pin_sync3.sv ***
`default_nettype none
module pin_sync3 #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             core_clk, // System clock
	input  wire logic             nrst,     // Async reset, active low
	input  wire logic             ce,       // Clock enable
	input  wire logic [WIDTH-1:0] async_in, // Pins from outside the domain
	output logic      [WIDTH-1:0] sync_out  // Settled copy
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;

	// A bit only moves once the second and third stage agree
	always_comb begin
		out_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q  <= RESET_VAL;
			s2_q  <= RESET_VAL;
			s3_q  <= RESET_VAL;
			out_q <= RESET_VAL;
		end else if (ce) begin
			s1_q  <= async_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign sync_out = out_q;
endmodule : pin_sync3
`default_nettype wire

// *** hw/ptr_gray_sync.sv ***
`default_nettype none
module ptr_gray_sync #(
	parameter int W = 17
) (
	input  wire logic         core_clk, // System clock
	input  wire logic         nrst,     // Async reset, active low
	input  wire logic         ce,       // Clock enable
	input  wire logic         clr,      // Synchronous clear to zero
	input  wire logic [W-1:0] ptr_in,   // Binary pointer, source side
	output logic      [W-1:0] ptr_out   // Binary pointer, far side
);
	logic [W-1:0] gray_q, m1_q, m2_q, gray_d, m1_d, m2_d;

	// Only one bit moves per step, so a torn sample is off by one at most
	always_comb begin
		gray_d = clr ? '0 : (ptr_in ^ (ptr_in >> 1));
		m1_d   = clr ? '0 : gray_q;
		m2_d   = clr ? '0 : m1_q;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			gray_q <= '0;
			m1_q   <= '0;
			m2_q   <= '0;
		end else if (ce) begin
			gray_q <= gray_d;
			m1_q   <= m1_d;
			m2_q   <= m2_d;
		end
	end

	always_comb begin
		ptr_out[W-1] = m2_q[W-1];
		for (int i = W - 2; i >= 0; i--) begin
			ptr_out[i] = ptr_out[i+1] ^ m2_q[i];
		end
	end
endmodule : ptr_gray_sync
`default_nettype wire

// *** hw/flagged_fifo.sv ***
`default_nettype none
`include "fifo_params.svh"

// Operation
// - Full clear zeroes both pointers and the output register.
// - Full clear latches timing mode, default offset and programming method.
// - Soft clear zeroes pointers and output, keeps mode, method and offsets.
// - Replay on a read edge rewinds the read pointer only.
// - During replay empty shows low, or valid shows not valid.
// - Mode pin picks timing during full clear, then is serial data.
// - Write edge stores the word, or loads offsets with offset access.
// - Serial enable shifts one bit per write edge into offsets.
// - Read edge presents next word, or offset contents with offset access.
// - Output enable alone decides whether read data is driven.
// - Offset access level at full clear picks 127 or 1023 and method.
// - Standard mode: full flag shows memory holds full capacity.
// - Fall-through mode: the same pin shows room for another word.
// - Standard mode: empty flag shows memory holds no words.
// - Fall-through mode: the same pin shows a valid word on outputs.
// - Almost-full goes low when count exceeds capacity minus full offset.
// - Almost-empty goes low when count is below the empty offset.
// - Half flag shows count above or below half capacity.
// - Default 127 pairs with parallel, 1023 with serial programming.
// - Fall-through: first word shows after three read clock transitions.
// - Offset readback works in both programming methods.
module flagged_fifo #(
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic        core_clk,              // 10 MHz system clock
	input  wire logic        nrst,                  // Async reset, active low
	input  wire logic        ce,                    // Clock enable, low freezes all
	input  wire logic        wclk,                  // Write clock pin
	input  wire logic        rclk,                  // Read clock pin
	input  wire logic        full_clear_n,          // Full clear pin
	input  wire logic        soft_clear_n,          // Partial clear pin
	input  wire logic        replay_request_n,      // Rewind read pointer
	input  wire logic        mode_select_serial_in, // Mode at clear, serial data after
	input  wire logic        write_enable_n,        // Write enable
	input  wire logic        read_enable_n,         // Read enable
	input  wire logic        bit_load_enable_n,     // Serial offset load enable
	input  wire logic        offset_access_n,       // Offset access
	input  wire logic        output_enable_n,       // Output enable
	input  wire logic [8:0]  write_data,            // Write data pins
	output logic      [8:0]  read_data,             // Read data pins
	output logic             read_data_oe,          // High while read data driven
	output logic             full_or_ready_n,       // Full flag or input ready
	output logic             empty_or_valid_n,      // Empty flag or output valid
	output logic             almost_full_level_n,   // Almost full flag
	output logic             almost_empty_level_n,  // Almost empty flag
	output logic             half_level_n,          // Half full flag
	input  wire logic        psel,                  // APB select
	input  wire logic        penable,               // APB enable
	input  wire logic        pwrite,                // APB direction
	input  wire logic [7:0]  paddr,                 // APB byte address
	input  wire logic [31:0] pwdata,                // APB write data
	output logic      [31:0] prdata,                // APB read data
	output logic             pready,                // APB ready
	output logic             pslverr                // APB error
);
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;

	// ----------------------------------------
	// Pin synchronisers and edge finders
	// ----------------------------------------
	logic [19:0] pins_s;
	logic        wclk_s, rclk_s, fc_n_s, sc_n_s, rp_n_s, mode_s;
	logic        we_n_s, re_n_s, ble_n_s, oa_n_s, oe_n_s;
	logic [8:0]  wd_s;
	logic        wclk_p_q, rclk_p_q;
	logic        wr_edge, rd_edge, rd_turn, full_clr, soft_clr;

	pin_sync3 #(
		.WIDTH     (20),
		.RESET_VAL (`PIN_RESET)
	) u_pins (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.async_in ({wclk, rclk, full_clear_n, soft_clear_n, replay_request_n,
			mode_select_serial_in, write_enable_n, read_enable_n,
			bit_load_enable_n, offset_access_n, output_enable_n, write_data}),
		.sync_out (pins_s)
	);

	assign {wclk_s, rclk_s, fc_n_s, sc_n_s, rp_n_s, mode_s} = pins_s[19:14];
	assign {we_n_s, re_n_s, ble_n_s, oa_n_s, oe_n_s} = pins_s[13:9];
	assign wd_s = pins_s[8:0];

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wclk_p_q <= 1'b0;
			rclk_p_q <= 1'b0;
		end else if (ce) begin
			wclk_p_q <= wclk_s;
			rclk_p_q <= rclk_s;
		end
	end

	logic sw_clear_q;
	assign wr_edge  = wclk_s & ~wclk_p_q;
	assign rd_edge  = rclk_s & ~rclk_p_q;
	assign rd_turn  = rclk_s ^ rclk_p_q;
	assign full_clr = ~fc_n_s;
	assign soft_clr = ~sc_n_s | sw_clear_q;

	// ----------------------------------------
	// Pointer crossing and levels
	// ----------------------------------------
	logic [PW-1:0] wptr_q, rptr_q, wptr_rv, rptr_wv, wr_level, rd_level;
	logic          mem_full, mem_empty;

	ptr_gray_sync #(.W(PW)) u_w2r (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.clr      (full_clr | soft_clr),
		.ptr_in   (wptr_q),
		.ptr_out  (wptr_rv)
	);
	ptr_gray_sync #(.W(PW)) u_r2w (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.clr      (full_clr | soft_clr),
		.ptr_in   (rptr_q),
		.ptr_out  (rptr_wv)
	);

	// Each side sees the other's pointer late, so both levels err safe
	assign wr_level  = wptr_q - rptr_wv;
	assign rd_level  = wptr_rv - rptr_q;
	assign mem_full  = (wr_level == PW'(DEPTH));
	assign mem_empty = (rd_level == '0);

	// ----------------------------------------
	// Write side: configuration, offsets, storage
	// ----------------------------------------
	fifo_pkg::word_t mem_q [DEPTH];
	logic            fall_through_mode_q, fall_through_mode_d, serial_q, serial_d, mem_we;
	logic [15:0]     e_ofs_q, e_ofs_d, f_ofs_q, f_ofs_d;
	logic [1:0]      ld_sel_q, ld_sel_d;
	logic [PW-1:0]   wptr_d;

	always_comb begin
		fall_through_mode_d   = fall_through_mode_q;
		serial_d = serial_q;
		e_ofs_d  = e_ofs_q;
		f_ofs_d  = f_ofs_q;
		ld_sel_d = ld_sel_q;
		wptr_d   = wptr_q;
		mem_we   = 1'b0;
		if (full_clr) begin
			fall_through_mode_d   = mode_s;
			serial_d = oa_n_s;
			e_ofs_d  = oa_n_s ? `OFS_DEFAULT_SER : `OFS_DEFAULT_PAR;
			f_ofs_d  = oa_n_s ? `OFS_DEFAULT_SER : `OFS_DEFAULT_PAR;
			ld_sel_d = 2'h0;
			wptr_d   = '0;
		end else if (soft_clr) begin
			ld_sel_d = 2'h0;
			wptr_d   = '0;
		end else if (wr_edge) begin
			if (!oa_n_s) begin
				if (!serial_q && !we_n_s) begin
					case (ld_sel_q)
						2'h0: e_ofs_d[8:0]  = wd_s;
						2'h1: e_ofs_d[15:9] = wd_s[6:0];
						2'h2: f_ofs_d[8:0]  = wd_s;
						default: f_ofs_d[15:9] = wd_s[6:0];
					endcase
					ld_sel_d = ld_sel_q + 2'h1;
				end else if (serial_q && !ble_n_s) begin
					// Empty offset first, low bit first, then full offset
					{f_ofs_d, e_ofs_d} = {mode_s, f_ofs_q, e_ofs_q[15:1]};
				end
			end else if (!we_n_s && !mem_full) begin
				mem_we = 1'b1;
				wptr_d = wptr_q + PW'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fall_through_mode_q   <= 1'b0;
			serial_q <= 1'b1;
			e_ofs_q  <= `OFS_DEFAULT_SER;
			f_ofs_q  <= `OFS_DEFAULT_SER;
			ld_sel_q <= 2'h0;
			wptr_q   <= '0;
		end else if (ce) begin
			fall_through_mode_q   <= fall_through_mode_d;
			serial_q <= serial_d;
			e_ofs_q  <= e_ofs_d;
			f_ofs_q  <= f_ofs_d;
			ld_sel_q <= ld_sel_d;
			wptr_q   <= wptr_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (ce && mem_we) begin
			mem_q[wptr_q[AW-1:0]] <= wd_s;
		end
	end

	// ----------------------------------------
	// Read side: output register and fall-through
	// ----------------------------------------
	function automatic fifo_pkg::word_t ofs_chunk(input logic [1:0] sel,
		input logic [15:0] e, input logic [15:0] f);
		case (sel)
			2'h0: ofs_chunk = e[8:0];
			2'h1: ofs_chunk = {2'h0, e[15:9]};
			2'h2: ofs_chunk = f[8:0];
			default: ofs_chunk = {2'h0, f[15:9]};
		endcase
	endfunction : ofs_chunk

	fifo_pkg::out_state_e ost_q, ost_d;
	fifo_pkg::word_t      out_q, out_d;
	logic [PW-1:0]        rptr_d;
	logic [1:0]           fall_q, fall_d, replay_q, replay_d, rb_sel_q, rb_sel_d;
	logic                 busy, valid;

	assign busy  = (replay_q != 2'h0);
	assign valid = fall_through_mode_q && (ost_q == fifo_pkg::out_held);

	always_comb begin
		ost_d    = ost_q;
		out_d    = out_q;
		rptr_d   = rptr_q;
		fall_d   = fall_q;
		replay_d = replay_q;
		rb_sel_d = rb_sel_q;
		if (full_clr || soft_clr) begin
			ost_d    = fifo_pkg::out_none;
			out_d    = '0;
			rptr_d   = '0;
			fall_d   = 2'h0;
			replay_d = 2'h0;
			rb_sel_d = 2'h0;
		end else begin
			if (rd_edge && busy) begin
				replay_d = replay_q - 2'h1;
			end
			if (rd_edge && !rp_n_s) begin
				rptr_d   = '0;
				replay_d = `REPLAY_EDGES;
				ost_d    = fifo_pkg::out_none;
				fall_d   = 2'h0;
			end else if (rd_edge && !re_n_s && !oa_n_s) begin
				out_d    = ofs_chunk(rb_sel_q, e_ofs_q, f_ofs_q);
				rb_sel_d = rb_sel_q + 2'h1;
			end else if (!fall_through_mode_q) begin
				if (rd_edge && !re_n_s && !mem_empty) begin
					out_d  = mem_q[rptr_q[AW-1:0]];
					rptr_d = rptr_q + PW'(1);
				end
			end else begin
				case (ost_q)
					fifo_pkg::out_none: begin
						fall_d = 2'h0;
						if (!mem_empty && !busy) begin
							ost_d = fifo_pkg::out_falling;
						end
					end
					fifo_pkg::out_falling: begin
						if (rd_turn) begin
							fall_d = fall_q + 2'h1;
							if (fall_q == `FALL_TRANSITIONS - 2'h1) begin
								out_d  = mem_q[rptr_q[AW-1:0]];
								rptr_d = rptr_q + PW'(1);
								ost_d  = fifo_pkg::out_held;
							end
						end
					end
					default: begin
						if (rd_edge && !re_n_s) begin
							if (!mem_empty) begin
								out_d  = mem_q[rptr_q[AW-1:0]];
								rptr_d = rptr_q + PW'(1);
							end else begin
								ost_d = fifo_pkg::out_none;
							end
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ost_q    <= fifo_pkg::out_none;
			out_q    <= '0;
			rptr_q   <= '0;
			fall_q   <= 2'h0;
			replay_q <= 2'h0;
			rb_sel_q <= 2'h0;
		end else if (ce) begin
			ost_q    <= ost_d;
			out_q    <= out_d;
			rptr_q   <= rptr_d;
			fall_q   <= fall_d;
			replay_q <= replay_d;
			rb_sel_q <= rb_sel_d;
		end
	end

	assign read_data    = out_q;
	assign read_data_oe = ~oe_n_s;

	// ----------------------------------------
	// Status flags, all active low
	// ----------------------------------------
	logic [4:0] flag_q, flag_d;

	always_comb begin
		flag_d[4] = fall_through_mode_q ? mem_full : ~mem_full;
		flag_d[3] = fall_through_mode_q ? (~valid | busy) : (~mem_empty & ~busy);
		// Wide compare so offsets above the depth saturate instead of wrapping
		flag_d[2] = ~((32'(wr_level) + 32'(f_ofs_q)) > 32'(DEPTH));
		flag_d[1] = ~(32'(rd_level) < 32'(e_ofs_q));
		flag_d[0] = ~(wr_level > PW'(DEPTH / 2));
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			flag_q <= 5'h1D;
		end else if (ce) begin
			flag_q <= flag_d;
		end
	end

	assign {full_or_ready_n, empty_or_valid_n, almost_full_level_n,
		almost_empty_level_n, half_level_n} = flag_q;

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	logic [31:0] prdata_q, prdata_d;
	logic        pslverr_q, pslverr_d, sw_clear_d;

	always_comb begin
		prdata_d   = prdata_q;
		pslverr_d  = pslverr_q;
		sw_clear_d = 1'b0;
		if (psel && !penable) begin
			prdata_d  = 32'h0000_0000;
			pslverr_d = 1'b0;
			if (paddr == `REG_CTRL) begin
				prdata_d = 32'h0000_0000;
			end else if (paddr == `REG_STATUS) begin
				prdata_d = {23'h0, flag_q, busy, valid, serial_q, fall_through_mode_q};
			end else if (paddr == `REG_OFFSETS) begin
				prdata_d = {f_ofs_q, e_ofs_q};
			end else if (paddr == `REG_LEVEL) begin
				prdata_d = 32'(wr_level);
			end else begin
				pslverr_d = 1'b1;
			end
		end
		if (psel && penable && pwrite && paddr == `REG_CTRL) begin
			sw_clear_d = pwdata[`CTRL_SOFT_CLEAR_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prdata_q   <= 32'h0000_0000;
			pslverr_q  <= 1'b0;
			sw_clear_q <= 1'b0;
		end else if (ce) begin
			prdata_q   <= prdata_d;
			pslverr_q  <= pslverr_d;
			sw_clear_q <= sw_clear_d;
		end
	end

	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;
	assign pready  = 1'b1;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_full_clear;
		ce && full_clr |=> wptr_q == '0 && rptr_q == '0 && out_q == '0;
	endproperty
	a_full_clear: assert property (p_full_clear)
		else $error("full clear left pointer or output set");

	property p_cfg_latch;
		ce && full_clr |=> fall_through_mode_q == $past(mode_s) && serial_q == $past(oa_n_s);
	endproperty
	a_cfg_latch: assert property (p_cfg_latch)
		else $error("configuration not latched during full clear");

	property p_defaults;
		ce && full_clr |=> f_ofs_q == e_ofs_q &&
			e_ofs_q == ($past(oa_n_s) ? `OFS_DEFAULT_SER : `OFS_DEFAULT_PAR);
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("wrong default offset");

	property p_soft_keep;
		ce && soft_clr && !full_clr |=> $stable(fall_through_mode_q) && $stable(serial_q) &&
			$stable(e_ofs_q) && $stable(f_ofs_q) && rptr_q == '0 && out_q == '0;
	endproperty
	a_soft_keep: assert property (p_soft_keep)
		else $error("soft clear disturbed settings");

	property p_replay;
		ce && !full_clr && !soft_clr && rd_edge && !rp_n_s |=>
			rptr_q == '0 && $stable(e_ofs_q) && replay_q == `REPLAY_EDGES;
	endproperty
	a_replay: assert property (p_replay)
		else $error("replay did not rewind read pointer");

	property p_replay_flag;
		ce && busy && !fall_through_mode_q |=> empty_or_valid_n == 1'b0;
	endproperty
	a_replay_flag: assert property (p_replay_flag)
		else $error("empty flag not low during replay");

	property p_mem_write;
		ce && !full_clr && !soft_clr && wr_edge && !we_n_s && oa_n_s && !mem_full
			|=> wptr_q == $past(wptr_q) + PW'(1);
	endproperty
	a_mem_write: assert property (p_mem_write)
		else $error("write edge did not advance write pointer");

	property p_serial;
		ce && !full_clr && !soft_clr && wr_edge && serial_q && !oa_n_s && !ble_n_s
			|=> f_ofs_q[15] == $past(mode_s) && e_ofs_q[15] == $past(f_ofs_q[0]);
	endproperty
	a_serial: assert property (p_serial)
		else $error("serial bit not shifted in");

	property p_std_full;
		ce && !fall_through_mode_q && mem_full |=> full_or_ready_n == 1'b0;
	endproperty
	a_std_full: assert property (p_std_full)
		else $error("full flag not low at capacity");

	property p_fall_three;
		ce && !full_clr && !soft_clr && fall_through_mode_q && ost_q == fifo_pkg::out_falling &&
			rd_turn && rp_n_s && oa_n_s && fall_q == 2'h2 |=> ost_q == fifo_pkg::out_held
			&& rptr_q == $past(rptr_q) + PW'(1);
	endproperty
	a_fall_three: assert property (p_fall_three)
		else $error("first word did not fall through on third transition");

	property p_half;
		ce && wr_level > PW'(DEPTH / 2) |=> half_level_n == 1'b0;
	endproperty
	a_half: assert property (p_half)
		else $error("half flag not low above half capacity");
endmodule : flagged_fifo
`default_nettype wire

// *** tb/link_peer.sv ***
`default_nettype none
// Writer and reader logic on the far side of the link pins
module link_peer (
	output logic       wclk,                  // Write link clock
	output logic       rclk,                  // Read link clock
	output logic       write_enable_n,        // Write enable
	output logic       read_enable_n,         // Read enable
	output logic       bit_load_enable_n,     // Serial load enable
	output logic       offset_access_n,       // Offset access
	output logic       replay_request_n,      // Replay request
	output logic       mode_select_serial_in, // Mode or serial bit
	output logic [8:0] write_data             // Write data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{wclk, rclk, write_data} = 11'h000;
		{write_enable_n, read_enable_n, bit_load_enable_n} = 3'h7;
		{offset_access_n, replay_request_n, mode_select_serial_in} = 3'h6;
	end
	// ----------------------------------------
	// Frames
	// ----------------------------------------
	// Odd start offset keeps link edges off the core clock edges
	// Clocks stand still between frames; lines released show inverted data
	task automatic wr(input logic [8:0] d, input logic w, input logic l, input logic s,
		input logic b);
		#37;
		write_data = d;
		write_enable_n = w;
		offset_access_n = l;
		bit_load_enable_n = s;
		mode_select_serial_in = b;
		#400 wclk = 1'b1;
		#400 wclk = 1'b0;
		{write_enable_n, bit_load_enable_n, offset_access_n} = 3'h7;
		write_data = ~d;
		mode_select_serial_in = ~b;
		#800;
	endtask : wr
	task automatic rd(input logic r, input logic l, input logic t);
		#37;
		read_enable_n = r;
		offset_access_n = l;
		replay_request_n = t;
		#400 rclk = 1'b1;
		#400 rclk = 1'b0;
		{read_enable_n, offset_access_n, replay_request_n} = 3'h7;
		#800;
	endtask : rd
	task automatic tog;
		rclk = ~rclk;
		#400;
	endtask : tog
	task automatic cfg(input logic m, input logic l);
		mode_select_serial_in = m;
		offset_access_n = l;
	endtask : cfg
endmodule : link_peer
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk, nrst, full_clear_n, soft_clear_n, output_enable_n;
	logic        wclk, rclk, write_enable_n, read_enable_n, bit_load_enable_n;
	logic        offset_access_n, replay_request_n, mode_select_serial_in;
	logic [8:0]  write_data, read_data;
	logic        read_data_oe, full_or_ready_n, empty_or_valid_n;
	logic        almost_full_level_n, almost_empty_level_n, half_level_n;
	logic        psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	int          n_mismatch, n_tests;
	always #50 core_clk = ~core_clk;
	// Small memory so that full and half levels are reached quickly
	flagged_fifo #(.DEPTH(16)) dut_u (.core_clk, .nrst, .ce(1'b1), .wclk, .rclk,
		.full_clear_n, .soft_clear_n, .replay_request_n, .mode_select_serial_in,
		.write_enable_n, .read_enable_n, .bit_load_enable_n, .offset_access_n,
		.output_enable_n, .write_data, .read_data, .read_data_oe, .full_or_ready_n,
		.empty_or_valid_n, .almost_full_level_n, .almost_empty_level_n, .half_level_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	link_peer peer_u (.wclk, .rclk, .write_enable_n, .read_enable_n, .bit_load_enable_n,
		.offset_access_n, .replay_request_n, .mode_select_serial_in, .write_data);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic fclr(input logic m, input logic l);
		peer_u.cfg(m, l);
		@(posedge core_clk);
		full_clear_n <= 1'b0;
		cyc(10);
		full_clear_n <= 1'b1;
		cyc(10);
		peer_u.cfg(1'b0, 1'b1);
	endtask : fclr
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_std;
		fclr(1'b0, 1'b1);
		chk(read_data, 0);
		chk(empty_or_valid_n, 0);
		chk(full_or_ready_n, 1);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdat[1:0], 2'b10);
		apb(1'b0, 8'h08, 32'h0);
		chk(rdat, 32'h03FF03FF);
		$display("standard clear done");
	endtask : t_std
	task automatic t_ser;
		// Empty offset first, each half least significant bit first
		for (int i = 0; i < 32; i++) peer_u.wr(9'h000, 1'b1, 1'b0, 1'b0, i == 2 || i == 18);
		apb(1'b0, 8'h08, 32'h0);
		chk(rdat, 32'h00040004);
		$display("serial load done");
	endtask : t_ser
	task automatic t_fill;
		// One word beyond capacity must be refused
		for (int i = 0; i < 17; i++) peer_u.wr(9'(9'h100 + i), 1'b0, 1'b1, 1'b1, 1'b0);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rdat, 32'h10);
		chk(full_or_ready_n, 0);
		chk(almost_full_level_n, 0);
		chk(half_level_n, 0);
		chk(almost_empty_level_n, 1);
		$display("fill done");
	endtask : t_fill
	task automatic t_read;
		peer_u.rd(1'b0, 1'b1, 1'b1);
		chk(read_data, 9'h100);
		peer_u.rd(1'b0, 1'b1, 1'b1);
		chk(read_data, 9'h101);
		peer_u.rd(1'b1, 1'b1, 1'b0);
		chk(empty_or_valid_n, 0);
		peer_u.rd(1'b1, 1'b1, 1'b1);
		peer_u.rd(1'b1, 1'b1, 1'b1);
		peer_u.rd(1'b0, 1'b1, 1'b1);
		chk(read_data, 9'h100);
		output_enable_n <= 1'b1;
		cyc(8);
		chk(read_data_oe, 0);
		output_enable_n <= 1'b0;
		cyc(8);
		chk(read_data_oe, 1);
		$display("read and replay done");
	endtask : t_read
	task automatic t_ofs;
		for (int i = 0; i < 4; i++) begin
			peer_u.rd(1'b0, 1'b0, 1'b1);
			chk(read_data, (i % 2) ? 0 : 4);
		end
		$display("offset readback done");
	endtask : t_ofs
	task automatic t_soft;
		apb(1'b1, 8'h00, 32'h1);
		cyc(20);
		chk(read_data, 0);
		chk(empty_or_valid_n, 0);
		chk(almost_empty_level_n, 0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rdat, 32'h00040004);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdat[1:0], 2'b10);
		apb(1'b0, 8'h10, 32'h0);
		chk(rerr, 1);
		$display("soft clear done");
	endtask : t_soft
	task automatic t_ft;
		fclr(1'b1, 1'b0);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdat[1:0], 2'b01);
		apb(1'b0, 8'h08, 32'h0);
		chk(rdat, 32'h007F007F);
		chk(full_or_ready_n, 0);
		chk(empty_or_valid_n, 1);
		peer_u.wr(9'h0A5, 1'b0, 1'b1, 1'b1, 1'b0);
		repeat (3) peer_u.tog;
		cyc(10);
		chk(read_data, 9'h0A5);
		chk(empty_or_valid_n, 0);
		peer_u.tog;
		for (int i = 0; i < 4; i++) peer_u.wr(9'(2 * i + 3), 1'b0, 1'b0, 1'b1, 1'b0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rdat, 32'h12070A03);
		for (int i = 0; i < 4; i++) begin
			peer_u.rd(1'b0, 1'b0, 1'b1);
			chk(read_data, 2 * i + 3);
		end
		peer_u.rd(1'b1, 1'b1, 1'b0);
		chk(empty_or_valid_n, 1);
		repeat (2) peer_u.rd(1'b1, 1'b1, 1'b1);
		repeat (2) peer_u.tog;
		cyc(10);
		chk(read_data, 9'h0A5);
		$display("fall-through done");
	endtask : t_ft
	task automatic complete_run;
		$display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run
	initial begin
		{core_clk, nrst, psel, penable, pwrite, output_enable_n} = 6'h0;
		{full_clear_n, soft_clear_n, paddr, pwdata} = 42'h30000000000;
		n_mismatch = 0;
		n_tests = 0;
		cyc(8);
		nrst <= 1'b1;
		t_std;
		t_ser;
		t_fill;
		t_read;
		t_ofs;
		t_soft;
		t_ft;
		complete_run;
	end
	initial begin
		#5000000;
		n_mismatch++;
		complete_run;
	end
endmodule : tb_top
`default_nettype wire
